// [caf_pkg.sv]
// Package of constants and types for the CAN receive acceptance filter.
package caf_pkg;
	// ==================================================================
	// Register byte addresses.
	localparam logic [7:0] OFF_FSID = 8'h00;
	localparam logic [7:0] OFF_FEXT = 8'h40;
	localparam logic [7:0] OFF_SEL_LO = 8'h80;
	localparam logic [7:0] OFF_SEL_HI = 8'h84;
	localparam logic [7:0] OFF_MSID = 8'h88;
	localparam logic [7:0] OFF_MEXT = 8'h94;
	localparam logic [7:0] OFF_FULL_LO = 8'ha0;
	localparam logic [7:0] OFF_FULL_HI = 8'ha4;
	localparam logic [7:0] OFF_OVF_LO = 8'ha8;
	localparam logic [7:0] OFF_OVF_HI = 8'hac;
	localparam logic [7:0] OFF_FEN = 8'hb0;
	localparam logic [7:0] OFF_BP = 8'hb4;
	localparam logic [7:0] OFF_IST = 8'hc4;
	localparam logic [7:0] OFF_IMASK = 8'hc8;
	// ==================================================================
	// Field positions in the standard-ID registers.
	localparam int SID_LSB = 5;
	localparam int SID_W = 11;
	localparam int TYPE_BIT = 3;
	localparam int EXTHI_W = 2;
	localparam int EID_W = 18;
	localparam logic [15:0] STD_WMASK = 16'hffeb;
	// ==================================================================
	// Reset values and codes.
	localparam logic [15:0] FEN_RST = 16'hffff;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [1:0] MSEL_RSVD = 2'h3;
	localparam logic [3:0] BP_FIFO = 4'hf;
	localparam int IRQ_ACC = 0;
	localparam int IRQ_OVF = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Whole state of the filter block.
	typedef struct packed {
		logic [15:0][15:0] fsid;
		logic [15:0][15:0] fext;
		logic [15:0] sel_lo;
		logic [15:0] sel_hi;
		logic [2:0][15:0] msid;
		logic [2:0][15:0] mext;
		logic [31:0] full;
		logic [31:0] ovf;
		logic [15:0] fen;
		logic [3:0][15:0] bp;
		logic [1:0] ist;
		logic [1:0] imask;
		logic aw_have;
		logic w_have;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic acc_valid;
		logic acc_fifo;
		logic [4:0] acc_buf;
		logic [4:0] acc_hit;
	} caf_state_t;
endpackage

// [caf_rx_filter.sv]
// Receive acceptance filter, buffer status flags and AXI4-Lite registers.
//
// Overview of operation
// (RL1) Compared standard ID bits must equal filter.
// (RL2) Compared 18 extended ID bits must equal.
// (RL3) Type enforce uses filter extended select bit.
// (RL4) Two-bit source picks mask 0, 1, 2.
// (RL5) Mask sources packed two bits per filter.
// (RL6) Mask standard bit one means compare it.
// (RL7) Mask extended bit one means compare it.
// (RL8) Enforced type must match extended select bit.
// (RL9) Without enforce, either frame type may match.
// (RL10) Set buffer full flag when buffer filled.
// (RL11) Software clears full flags after emptying buffer.
// (RL12) Set overflow when writing an already full buffer.
// (RL13) Software clears overflow flags by writing.
// (RL14) Unimplemented standard-ID bits 4, 2 read zero.
// (RL15) Disabled filters never take part in acceptance.
// (RL16) Hit stores frame at pointer; 1111 means FIFO.
// (RL17) Record hitting filter number as hit code.
// (RL18) Hit needs all compared bits and type match.
`timescale 1ns/1ps
`default_nettype none
module caf_rx_filter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic frm_valid,
	input wire logic [10:0] frm_sid,
	input wire logic [17:0] frm_eid,
	input wire logic frm_ext,
	input wire logic [4:0] fifo_buf_idx,
	output logic acc_valid,
	output logic [4:0] acc_buf,
	output logic acc_fifo,
	output logic [4:0] acc_hit,
	output logic irq
);
	import caf_pkg::*;

	caf_state_t st_reg;
	caf_state_t st_next;

	// ==================================================================
	// Filter matching.
	// One filter against the incoming frame; a reserved mask source never
	// hits, so a misprogrammed filter stays silent instead of matching all.
	function automatic logic filt_hit(input caf_state_t s, input int i,
			input logic [10:0] sid, input logic [17:0] eid,
			input logic ext);
		logic [1:0] sel;
		logic [15:0] fs;
		logic [15:0] ms;
		logic [17:0] fe;
		logic [17:0] me;
		logic sid_ok;
		logic eid_ok;
		logic type_ok;
		sel = (i < 8) ? s.sel_lo[2*i +: 2] : s.sel_hi[2*(i-8) +: 2]; // [RL5]
		fs = s.fsid[i];
		ms = (sel == MSEL_RSVD) ? 16'h0000 : s.msid[sel]; // [RL4]
		fe = {fs[EXTHI_W-1:0], s.fext[i]};
		me = {ms[EXTHI_W-1:0], (sel == MSEL_RSVD) ? 16'h0000 : s.mext[sel]};
		sid_ok = ((fs[SID_LSB +: SID_W] ^ sid)
			& ms[SID_LSB +: SID_W]) == 11'h000; // [RL1] [RL6]
		eid_ok = ((fe ^ eid) & me) == 18'h00000; // [RL2] [RL7]
		type_ok = !ms[TYPE_BIT] || (fs[TYPE_BIT] == ext); // [RL3] [RL8]
		filt_hit = (sel != MSEL_RSVD) && s.fen[i] && type_ok // [RL15]
			&& sid_ok && (!ext || eid_ok); // [RL9] [RL18]
	endfunction

	// Byte-lane merge for the 16-bit registers.
	function automatic logic [15:0] wr16(input logic [15:0] old,
			input logic [31:0] d, input logic [3:0] strb);
		wr16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction

	// Read decode; bit 0 of the result flags a mapped address.
	function automatic logic [32:0] rd_dec(input caf_state_t s,
			input logic [7:0] a);
		logic [32:0] r;
		r = {16'h0000, 16'h0000, 1'b1};
		if (a < OFF_FEXT)
			r[16:1] = s.fsid[a[5:2]] & STD_WMASK; // [RL14]
		else if (a < OFF_SEL_LO)
			r[16:1] = s.fext[a[5:2]];
		else if (a >= OFF_MSID && a < OFF_MEXT)
			r[16:1] = s.msid[2'((a - OFF_MSID) >> 2)] & STD_WMASK; // [RL14]
		else if (a >= OFF_MEXT && a < OFF_FULL_LO)
			r[16:1] = s.mext[2'((a - OFF_MEXT) >> 2)];
		else if (a >= OFF_BP && a < OFF_IST)
			r[16:1] = s.bp[2'((a - OFF_BP) >> 2)];
		else begin
			unique case (a)
				OFF_SEL_LO: r[16:1] = s.sel_lo;
				OFF_SEL_HI: r[16:1] = s.sel_hi;
				OFF_FULL_LO: r[16:1] = s.full[15:0];
				OFF_FULL_HI: r[16:1] = s.full[31:16];
				OFF_OVF_LO: r[16:1] = s.ovf[15:0];
				OFF_OVF_HI: r[16:1] = s.ovf[31:16];
				OFF_FEN: r[16:1] = s.fen;
				OFF_IST: r[2:1] = s.ist;
				OFF_IMASK: r[2:1] = s.imask;
				default: r[0] = 1'b0;
			endcase
		end
		if (a[1:0] != 2'h0)
			r[0] = 1'b0;
		rd_dec = r;
	endfunction

	// ==================================================================
	// Next-state logic.
	// The lowest-numbered hitting filter wins when several hit at once.
	always_comb begin
		logic hit_any;
		logic [3:0] hit_idx;
		logic [3:0] ptr;
		logic [4:0] tgt;
		logic [31:0] set_full;
		logic [31:0] set_ovf;
		logic [31:0] clr_full;
		logic [31:0] clr_ovf;
		logic [1:0] set_ist;
		logic [1:0] clr_ist;
		logic [7:0] a;
		logic [32:0] rd;
		hit_any = 1'b0;
		hit_idx = 4'h0;
		ptr = 4'h0;
		tgt = 5'h00;
		set_full = 32'h00000000;
		set_ovf = 32'h00000000;
		clr_full = 32'h00000000;
		clr_ovf = 32'h00000000;
		set_ist = 2'h0;
		clr_ist = 2'h0;
		a = st_reg.awaddr;
		rd = 33'h000000000;
		st_next = st_reg;
		st_next.acc_valid = 1'b0;

		// Acceptance of one frame per frm_valid pulse.
		for (int i = 15; i >= 0; i--) begin
			if (filt_hit(st_reg, i, frm_sid, frm_eid, frm_ext)) begin
				hit_any = 1'b1;
				hit_idx = 4'(i);
			end
		end
		if (frm_valid && hit_any) begin
			ptr = st_reg.bp[hit_idx[3:2]][4*hit_idx[1:0] +: 4];
			tgt = (ptr == BP_FIFO) ? fifo_buf_idx : {1'b0, ptr}; // [RL16]
			set_full[tgt] = 1'b1; // [RL10]
			set_ovf[tgt] = st_reg.full[tgt]; // [RL12]
			set_ist[IRQ_ACC] = 1'b1;
			set_ist[IRQ_OVF] = st_reg.full[tgt];
			st_next.acc_valid = 1'b1;
			st_next.acc_buf = tgt;
			st_next.acc_fifo = (ptr == BP_FIFO); // [RL16]
			st_next.acc_hit = {1'b0, hit_idx}; // [RL17]
		end

		// Write channel: address and data are taken in either order.
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_have = 1'b1;
			st_next.awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_have = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
		end
		if (st_reg.aw_have && st_reg.w_have) begin
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.bvalid = 1'b1;
			rd = rd_dec(st_reg, a);
			st_next.bresp = rd[0] ? RESP_OKAY : RESP_SLVERR;
			if (a[1:0] != 2'h0) begin
				st_next.bresp = RESP_SLVERR;
			end else if (a < OFF_FEXT) begin
				st_next.fsid[a[5:2]] = wr16(st_reg.fsid[a[5:2]],
					st_reg.wdata, st_reg.wstrb) & STD_WMASK; // [RL14]
			end else if (a < OFF_SEL_LO) begin
				st_next.fext[a[5:2]] = wr16(st_reg.fext[a[5:2]],
					st_reg.wdata, st_reg.wstrb);
			end else if (a >= OFF_MSID && a < OFF_MEXT) begin
				st_next.msid[2'((a - OFF_MSID) >> 2)] = wr16(
					st_reg.msid[2'((a - OFF_MSID) >> 2)],
					st_reg.wdata, st_reg.wstrb) & STD_WMASK;
			end else if (a >= OFF_MEXT && a < OFF_FULL_LO) begin
				st_next.mext[2'((a - OFF_MEXT) >> 2)] = wr16(
					st_reg.mext[2'((a - OFF_MEXT) >> 2)],
					st_reg.wdata, st_reg.wstrb);
			end else if (a >= OFF_BP && a < OFF_IST) begin
				st_next.bp[2'((a - OFF_BP) >> 2)] = wr16(
					st_reg.bp[2'((a - OFF_BP) >> 2)],
					st_reg.wdata, st_reg.wstrb);
			end else begin
				unique case (a)
					OFF_SEL_LO: st_next.sel_lo = wr16(st_reg.sel_lo,
						st_reg.wdata, st_reg.wstrb);
					OFF_SEL_HI: st_next.sel_hi = wr16(st_reg.sel_hi,
						st_reg.wdata, st_reg.wstrb);
					OFF_FEN: st_next.fen = wr16(st_reg.fen,
						st_reg.wdata, st_reg.wstrb);
					OFF_FULL_LO: clr_full[15:0] = wr16(REG_RST,
						st_reg.wdata, st_reg.wstrb); // [RL11]
					OFF_FULL_HI: clr_full[31:16] = wr16(REG_RST,
						st_reg.wdata, st_reg.wstrb); // [RL11]
					OFF_OVF_LO: clr_ovf[15:0] = wr16(REG_RST,
						st_reg.wdata, st_reg.wstrb); // [RL13]
					OFF_OVF_HI: clr_ovf[31:16] = wr16(REG_RST,
						st_reg.wdata, st_reg.wstrb); // [RL13]
					OFF_IST: clr_ist = st_reg.wstrb[0] ?
						st_reg.wdata[1:0] : 2'h0;
					OFF_IMASK: st_next.imask = st_reg.wstrb[0] ?
						st_reg.wdata[1:0] : st_reg.imask;
					default: st_next.bresp = RESP_SLVERR;
				endcase
			end
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// Sticky flags: a hardware set in the clearing cycle wins.
		st_next.full = (st_reg.full & ~clr_full) | set_full; // [RL10] [RL11]
		st_next.ovf = (st_reg.ovf & ~clr_ovf) | set_ovf; // [RL12] [RL13]
		st_next.ist = (st_reg.ist & ~clr_ist) | set_ist;

		// Read channel: answer one cycle after the address is taken.
		if (s_axi_arvalid && s_axi_arready) begin
			rd = rd_dec(st_reg, s_axi_araddr[7:0]);
			st_next.rvalid = 1'b1;
			st_next.rdata = {16'h0000, rd[16:1]};
			st_next.rresp = (rd[0] && s_axi_araddr[31:8] == 24'h000000) ?
				RESP_OKAY : RESP_SLVERR;
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
	end

	// State register; filter patterns and masks clear on reset as well.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.fen <= FEN_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==================================================================
	// Outputs.
	// Address and data are refused while one write is still pending.
	assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
	assign s_axi_wready = !st_reg.w_have && !st_reg.bvalid;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign acc_valid = st_reg.acc_valid;
	assign acc_buf = st_reg.acc_buf;
	assign acc_fifo = st_reg.acc_fifo;
	assign acc_hit = st_reg.acc_hit;
	assign irq = |(st_reg.ist & st_reg.imask);

	// ==================================================================
	// Assertions.
	a_full_set: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_valid |-> st_reg.full[acc_buf]) // [RL10]
		else $error("Accepted buffer not marked full.");
	a_ovf_set: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_valid && $past(st_reg.full[st_next.acc_buf]) |->
		st_reg.ovf[acc_buf]) // [RL12]
		else $error("Write to full buffer not flagged as overflow.");
	a_full_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(st_reg.full[0]) |-> $past(st_reg.aw_have
		&& st_reg.w_have && st_reg.awaddr == OFF_FULL_LO)) // [RL11]
		else $error("Full flag cleared without a software write.");
	a_ovf_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(st_reg.ovf[31]) |-> $past(st_reg.aw_have
		&& st_reg.w_have && st_reg.awaddr == OFF_OVF_HI)) // [RL13]
		else $error("Overflow flag cleared without a software write.");
	a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.fsid[0][4] == 1'b0) && (st_reg.msid[0][2] == 1'b0)) // [RL14]
		else $error("Unimplemented standard-ID bit holds a one.");
	a_fifo_code: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_valid |-> acc_fifo == ($past(st_reg.bp[st_next.acc_hit[3:2]]
		[4*st_next.acc_hit[1:0] +: 4]) == BP_FIFO)) // [RL16]
		else $error("FIFO routing disagrees with the buffer pointer.");
	a_fifo_target: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_valid && acc_fifo |-> acc_buf == $past(fifo_buf_idx)) // [RL16]
		else $error("FIFO frame stored in the wrong buffer.");
	// Flags rise only when a frame is stored, never through the bus.
	a_full_by_hw: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.full & ~$past(st_reg.full)) != 32'h00000000
		|-> $past(frm_valid)) // [RL10]
		else $error("Full flag set without a received frame.");
	a_ovf_by_hw: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.ovf & ~$past(st_reg.ovf)) != 32'h00000000
		|-> $past(frm_valid && st_reg.full != 32'h00000000)) // [RL12]
		else $error("Overflow flag set without a frame to a full buffer.");
	a_hit_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
		acc_valid |-> $past(st_reg.fen[st_next.acc_hit[3:0]])) // [RL15]
		else $error("Disabled filter accepted a frame.");
	a_no_frame: assert property (@(posedge aclk) disable iff (!aresetn)
		!frm_valid |=> !acc_valid) // [RL18]
		else $error("Accept pulse without a frame.");
	a_type_check: assert property (@(posedge aclk) disable iff (!aresetn)
		frm_valid && st_reg.fen == 16'h0001 && st_reg.sel_lo[1:0] == 2'h0
		&& st_reg.msid[0][TYPE_BIT] && st_reg.fsid[0][TYPE_BIT] != frm_ext
		|=> !acc_valid) // [RL3] [RL8]
		else $error("Frame of wrong type accepted.");
	a_rsvd_sel: assert property (@(posedge aclk) disable iff (!aresetn)
		frm_valid && st_reg.fen == 16'h0001
		&& st_reg.sel_lo[1:0] == MSEL_RSVD |=> !acc_valid) // [RL4]
		else $error("Reserved mask source produced a hit.");
	a_bresp_time: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg.aw_have && st_reg.w_have |=> s_axi_bvalid)
		else $error("Write answer late.");
endmodule // caf_rx_filter
`default_nettype wire

// [caf_frame_src.sv]
// Frame source model standing in for the CAN bus side of the filter.
`timescale 1ns/1ps
`default_nettype none
module caf_frame_src (
	input wire logic aclk,
	output logic frm_valid,
	output logic [10:0] frm_sid,
	output logic [17:0] frm_eid,
	output logic frm_ext
);
	// ==========================================================
	// Idle lines show an alternating bit pattern so a stale id never looks valid.
	initial begin
		frm_valid = 1'b0;
		frm_sid = 11'h2aa;
		frm_eid = 18'h15555;
		frm_ext = 1'b0;
	end
	// One-cycle offer; the id is inverted once the frame has gone.
	task automatic send(input logic [10:0] s, input logic [17:0] e,
			input logic x);
		frm_valid <= 1'b1;
		frm_sid <= s;
		frm_eid <= e;
		frm_ext <= x;
		@(posedge aclk);
		frm_valid <= 1'b0;
		frm_sid <= ~s;
		frm_eid <= ~e;
		frm_ext <= ~x;
	endtask
endmodule // caf_frame_src
`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the receive acceptance filter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	import caf_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, m_ist, m_imask, r;
	logic frm_valid, frm_ext, acc_valid, acc_fifo;
	logic [10:0] frm_sid;
	logic [17:0] frm_eid;
	logic [4:0] fifo_buf_idx, acc_buf, acc_hit;
	logic [31:0] seed, d, m_sel, m_full, m_ovf;
	logic [15:0] m_fsid[16], m_fext[16], m_msid[3], m_mext[3], m_bp[4];
	logic [15:0] m_fen;
	int error_cnt, checked, k;
	caf_rx_filter dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frm_valid, .frm_sid,
		.frm_eid, .frm_ext, .fifo_buf_idx, .acc_valid, .acc_buf,
		.acc_fifo, .acc_hit, .irq);
	caf_frame_src src_u (.aclk, .frm_valid, .frm_sid, .frm_eid, .frm_ext);
	// ==========================================================
	// Clock, random source and closing.
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	task automatic results();
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// A hang costs a mismatch; normal runs end well inside this span.
	initial begin
		#300000;
		error_cnt++;
		results();
	end
	// ==========================================================
	// Bus cycles: payload held until its own ready, answer taken on valid.
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= {16'h0, v[15:0]};
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				break;
			end
		end
	endtask
	task automatic axr(input logic [7:0] a);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		axr(a);
		`CHK(d, {16'h0, e})
		`CHK(r, RESP_OKAY)
	endtask
	// Write a register and mirror its documented effect in the model.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [15:0] w;
		w = v[15:0];
		axw(a, v);
		`CHK(r, RESP_OKAY)
		if (a < OFF_FEXT) m_fsid[a[5:2]] = w & STD_WMASK;
		else if (a < OFF_SEL_LO) m_fext[a[5:2]] = w;
		else if (a == OFF_SEL_LO) m_sel[15:0] = w;
		else if (a == OFF_SEL_HI) m_sel[31:16] = w;
		else if (a < OFF_MEXT) m_msid[(a - OFF_MSID) >> 2] = w & STD_WMASK;
		else if (a < OFF_FULL_LO) m_mext[(a - OFF_MEXT) >> 2] = w;
		else if (a == OFF_FULL_LO) m_full[15:0] &= ~w;
		else if (a == OFF_FULL_HI) m_full[31:16] &= ~w;
		else if (a == OFF_OVF_LO) m_ovf[15:0] &= ~w;
		else if (a == OFF_OVF_HI) m_ovf[31:16] &= ~w;
		else if (a == OFF_FEN) m_fen = w;
		else if (a < OFF_IST) m_bp[(a - OFF_BP) >> 2] = w;
		else if (a == OFF_IST) m_ist &= ~w[1:0];
		else m_imask = w[1:0];
	endtask
	// ==========================================================
	// Reference acceptance: lowest enabled filter whose compares all pass.
	function automatic int hit_of(input logic [10:0] s,
			input logic [17:0] e, input logic x);
		logic [15:0] ms, fs;
		int m;
		for (int f = 0; f < 16; f++) begin
			m = (m_sel >> (2 * f)) & 3;
			fs = m_fsid[f];
			if (m != 3 && m_fen[f]) begin
				ms = m_msid[m];
				if (((fs[15:5] ^ s) & ms[15:5]) == 0 && !(ms[3] && fs[3] != x)
					&& (!x || (({fs[1:0], m_fext[f]} ^ e)
					& {ms[1:0], m_mext[m]}) == 0)) return f;
			end
		end
		return -1;
	endfunction
	// Offer one frame close to a random filter and check the verdict.
	task automatic frame();
		logic [31:0] t, u;
		logic [10:0] s;
		logic [17:0] e;
		logic x;
		logic [3:0] p;
		logic [4:0] b;
		int f;
		t = rnd();
		u = rnd();
		k = (m_fen == 16'h0001) ? 0 : u[8:5]; // Aim at the lone filter.
		s = m_fsid[k][15:5] ^ (t[0] ? t[11:1] : 11'h0);
		e = {m_fsid[k][1:0], m_fext[k]} ^ (t[13] ? t[31:14] : 18'h0);
		x = t[12] ? m_fsid[k][3] : u[9];
		fifo_buf_idx <= u[4:0];
		src_u.send(s, e, x);
		#1;
		f = hit_of(s, e, x);
		`CHK(acc_valid, f >= 0)
		if (f >= 0) begin
			p = m_bp[f / 4][4 * (f % 4) +: 4];
			b = p == BP_FIFO ? u[4:0] : {1'b0, p};
			`CHK(acc_fifo, p == BP_FIFO)
			`CHK(acc_buf, b)
			`CHK(acc_hit, 5'(f))
			if (m_full[b]) m_ist[IRQ_OVF] = 1'b1;
			if (m_full[b]) m_ovf[b] = 1'b1;
			m_full[b] = 1'b1;
			m_ist[IRQ_ACC] = 1'b1;
		end
		@(posedge aclk);
	endtask
	// ==========================================================
	// Main sequence.
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		{fifo_buf_idx, aresetn, m_ist, m_imask} = 10'h000;
		{m_sel, m_full, m_ovf, error_cnt, checked} = 160'h0;
		seed = 32'd74411;
		m_fen = FEN_RST;
		for (int i = 0; i < 16; i++) {m_fsid[i], m_fext[i]} = 32'h0;
		for (int i = 0; i < 4; i++) m_bp[i] = 16'h0;
		for (int i = 0; i < 3; i++) {m_msid[i], m_mext[i]} = 32'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_FEN, FEN_RST);
		rd(OFF_SEL_HI, REG_RST);
		rd(OFF_FULL_LO, REG_RST);
		rd(OFF_OVF_HI, REG_RST);
		axr(8'hfc);
		`CHK(r, RESP_SLVERR)
		axw(8'hfd, 32'h1);
		`CHK(r, RESP_SLVERR)
		wr(OFF_MSID, 32'hffff);
		rd(OFF_MSID, 16'hffeb);
		for (int n = 0; n < 6; n++) begin
			for (int i = 0; i < 16; i++) wr(OFF_FSID + 8'(4 * i), rnd());
			for (int i = 0; i < 16; i++) wr(OFF_FEXT + 8'(4 * i), rnd());
			for (int i = 0; i < 3; i++) wr(OFF_MSID + 8'(4 * i),
				rnd() & rnd() | (n == 0 ? 32'h8 : 32'h0));
			for (int i = 0; i < 3; i++) wr(OFF_MEXT + 8'(4 * i), rnd() & rnd());
			for (int i = 0; i < 4; i++) wr(OFF_BP + 8'(4 * i), rnd());
			// Pass 0 enforces the type on filter 0 alone, pass 1 makes its
			// mask source reserved; later passes are fully random.
			wr(OFF_SEL_LO, n == 0 ? 32'he4e4 :
				n == 1 ? rnd() | 32'h3 : rnd());
			wr(OFF_SEL_HI, rnd());
			wr(OFF_FEN, n < 2 ? 32'h1 : rnd() | rnd());
			wr(OFF_IMASK, rnd());
			k = n * 3;
			rd(OFF_FSID + 8'(4 * k), m_fsid[k]);
			rd(OFF_FEXT + 8'(4 * k), m_fext[k]);
			repeat (40) frame();
			rd(OFF_FULL_LO, m_full[15:0]);
			rd(OFF_FULL_HI, m_full[31:16]);
			rd(OFF_OVF_LO, m_ovf[15:0]);
			rd(OFF_OVF_HI, m_ovf[31:16]);
			rd(OFF_IST, {14'h0, m_ist});
			`CHK(irq, |(m_ist & m_imask))
			wr(OFF_FULL_LO, rnd());
			wr(OFF_FULL_HI, rnd());
			wr(OFF_OVF_LO, rnd());
			wr(OFF_OVF_HI, rnd());
			wr(OFF_IST, rnd());
		end
		results();
	end
endmodule // tb_top
`default_nettype wire
